// ### design/cth_pkg.sv
// Constants, field layouts and frame carrier for the cyclic timer and
// hardware lock register bank.
// Assumes a 100 MHz system clock and an SPI front end that delivers decoded frames.
package cth_pkg;

    // ----------------------------------------------------------------
    // Addresses and field positions
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_TIMER = 7'h0c;
    localparam logic [6:0] ADDR_HWCTL = 7'h0e;

    localparam int ON_LSB = 4;
    localparam int ON_MSB = 6;
    localparam int PER_LSB = 0;
    localparam int PER_MSB = 3;
    localparam int HYST_BIT = 7;
    localparam int THERM_BIT = 5;
    localparam int RSTDEL_BIT = 4;
    localparam int LOCK0_BIT = 3;

    localparam logic [7:0] TIMER_RESET = 8'h00;
    localparam logic [7:0] TIMER_RD_MASK = 8'h7f;
    localparam logic [7:0] HWCTL_RD_MASK = 8'hb8;
    localparam logic [7:0] HWCTL_LOCK1_MASK = 8'hb0;
    localparam logic [7:0] HWCTL_POR = 8'h00;

    localparam logic [2:0] PINCFG_CYCLIC_SENSE = 3'h3;

    // ----------------------------------------------------------------
    // On-time codes
    // ----------------------------------------------------------------
    localparam logic [2:0] ON_OFF_LOW = 3'h0;
    localparam logic [2:0] ON_100US = 3'h1;
    localparam logic [2:0] ON_300US = 3'h2;
    localparam logic [2:0] ON_1MS = 3'h3;
    localparam logic [2:0] ON_10MS = 3'h4;
    localparam logic [2:0] ON_20MS = 3'h5;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;

    // ----------------------------------------------------------------
    // Timing: one tick is 0.1 ms, the finest on-time step
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 100000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 23;
    localparam int THERM_EVENT_LIMIT = 16;
    localparam int THERM_WAIT_FACTOR = 64;

    // On-time in ticks for each code.
    function automatic logic [TICK_W-1:0] on_ticks(input logic [2:0] code);
        logic [TICK_W-1:0] t;
        t = 23'h0;
        unique case (code)
            ON_100US: t = 23'h1;
            ON_300US: t = 23'h3;
            ON_1MS:   t = 23'ha;
            ON_10MS:  t = 23'h64;
            ON_20MS:  t = 23'hc8;
            default:  t = 23'h0;
        endcase
        return t;
    endfunction : on_ticks

    // Period in ticks, 10 ms up to 500 s; the top code repeats 500 s.
    function automatic logic [TICK_W-1:0] per_ticks(input logic [3:0] code);
        logic [TICK_W-1:0] t;
        t = 23'h64;
        unique case (code)
            4'h0: t = 23'h64;
            4'h1: t = 23'hc8;
            4'h2: t = 23'h1f4;
            4'h3: t = 23'h3e8;
            4'h4: t = 23'h7d0;
            4'h5: t = 23'h1388;
            4'h6: t = 23'h2710;
            4'h7: t = 23'h4e20;
            4'h8: t = 23'hc350;
            4'h9: t = 23'h186a0;
            4'ha: t = 23'h30d40;
            4'hb: t = 23'h7a120;
            4'hc: t = 23'hf4240;
            4'hd: t = 23'h1e8480;
            4'he: t = 23'h4c4b40;
            4'hf: t = 23'h4c4b40;
        endcase
        return t;
    endfunction : per_ticks

    // ----------------------------------------------------------------
    // Decoded SPI frame
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } cth_frame_t;

endpackage : cth_pkg

// ### design/cth_event_streak.sv
// Saturating counter of consecutive events with a threshold flag.
// Assumes event and clear are one-cycle pulses in the system clock domain.
`timescale 1ns/100ps
module cth_event_streak #(
    parameter int LIMIT = 16
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic event_i,
    input wire logic clear_i,
    output logic exceeded_o
);
    localparam int W = $clog2(LIMIT + 2);
    localparam logic [W-1:0] SAT = W'(LIMIT + 1);

    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    // An event in the clear cycle starts a new streak of one.
    assign nxt_count = event_i ? ((clear_i) ? W'(1) : ((count_ff == SAT) ? SAT : count_ff + W'(1)))
                               : (clear_i ? '0 : count_ff);
    assign exceeded_o = (count_ff == SAT);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule : cth_event_streak

// ### design/cth_cycle_timer.sv
// Cyclic on/off timer with a 0.1 ms prescaler.
// Assumes the codes take their new value on the cycle after load_i pulses.
`timescale 1ns/100ps
module cth_cycle_timer
    import cth_pkg::*;
#(
    parameter int TICK_CYC = cth_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [2:0] on_code_i,
    input wire logic [3:0] per_code_i,
    input wire logic load_i,
    output logic out_o,
    output logic period_start_o
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);

    logic [PW-1:0] pre_ff;
    logic [TICK_W-1:0] cnt_ff;
    logic out_ff;
    logic start_ff;
    logic load_ff;
    logic running;
    logic tick;
    logic wrap;
    logic [TICK_W-1:0] nxt_cnt;
    logic nxt_out;

    assign running = (on_code_i >= ON_100US) && (on_code_i <= ON_20MS);
    assign tick = (pre_ff == PRE_LAST);
    assign wrap = tick && (cnt_ff == per_ticks(per_code_i) - TICK_W'(1));
    assign nxt_cnt = (load_ff || wrap) ? '0 : (tick ? cnt_ff + TICK_W'(1) : cnt_ff);
    // High for the on-time from each period start, low for the rest; ON_OFF_HIGH holds it high.
    assign nxt_out = (on_code_i == ON_OFF_HIGH) ? 1'b1 :
                     (running && (nxt_cnt < on_ticks(on_code_i)));
    assign out_o = out_ff;
    assign period_start_o = start_ff;

    // The load acts one cycle late, so the restart already sees the new codes
    // and a fresh setting gets its period start pulse.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || load_ff || !running) begin
            pre_ff <= '0;
            cnt_ff <= '0;
        end else begin
            pre_ff <= tick ? '0 : pre_ff + PW'(1);
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            out_ff <= 1'b0;
            start_ff <= 1'b0;
            load_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            start_ff <= running && (load_ff || wrap);
            load_ff <= load_i;
        end
    end
endmodule : cth_cycle_timer

// ### design/cth_ctrl_regs.sv
// Timer control and hardware control registers with configuration locks.
// Assumes an SPI front end presents the decoded frame while chip select is
// low; the frame is committed on the rising edge of chip select.
`timescale 1ns/100ps
module cth_ctrl_regs #(
    parameter int TICK_CYC = cth_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic spi_chip_select_n_i,
    input wire cth_pkg::cth_frame_t frame_i,
    input wire logic [6:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic soft_reset_i,
    input wire logic restart_i,
    input wire logic restart_hs_cleared_i,
    input wire logic level1_lock_bit_i,
    input wire logic [2:0] pin_config_i,
    input wire logic timer_wake_enable_i,
    input wire logic level2_thermal_shutdown_i,
    input wire logic thermal_streak_clear_i,
    output logic high_side_output_o,
    output logic cyclic_sense_drive_o,
    output logic timer_wake_o,
    output logic undervoltage_hysteresis_select_o,
    output logic thermal_retry_delay_select_o,
    output logic thermal_wait_extended_o,
    output logic reset_delay_select_o,
    output logic level0_lock_o,
    output logic level1_lock_active_o,
    output logic cp_pincfg_write_permit_o
);
    import cth_pkg::*;

    // ----------------------------------------------------------------
    // Frame commit on chip select rise
    // ----------------------------------------------------------------
    logic cs_n_ff;
    logic cs_rise;
    logic wr_timer;
    logic wr_hwctl;

    assign cs_rise = spi_chip_select_n_i && !cs_n_ff;
    assign wr_timer = cs_rise && frame_i.wr && (frame_i.addr == ADDR_TIMER);
    assign wr_hwctl = cs_rise && frame_i.wr && (frame_i.addr == ADDR_HWCTL);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cs_n_ff <= 1'b1;
        end else begin
            cs_n_ff <= spi_chip_select_n_i;
        end
    end

    // ----------------------------------------------------------------
    // Level-1 lock arming
    // ----------------------------------------------------------------
    // The lock only arms at a chip select rise, so the frame that sets the
    // lock bit may still finish its own writes. Only power-on releases it.
    logic lock1_ff;
    logic nxt_lock1;

    assign nxt_lock1 = lock1_ff || (cs_rise && level1_lock_bit_i);
    assign level1_lock_active_o = lock1_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            lock1_ff <= 1'b0;
        end else begin
            lock1_ff <= nxt_lock1;
        end
    end

    // ----------------------------------------------------------------
    // Timer control register
    // ----------------------------------------------------------------
    logic [2:0] on_code_ff;
    logic [3:0] per_code_ff;
    logic [2:0] nxt_on_code;
    logic [3:0] nxt_per_code;
    logic sense_mode;
    logic timer_clear;
    logic timer_load;

    assign sense_mode = (pin_config_i == PINCFG_CYCLIC_SENSE);
    // Clearing in restart avoids a stale sense pulse being read as a switch
    // event. Other failures deliberately leave the timer running.
    assign timer_clear = soft_reset_i || restart_i || (restart_hs_cleared_i && sense_mode);
    assign nxt_on_code = timer_clear ? TIMER_RESET[ON_MSB:ON_LSB] :
                         (wr_timer ? frame_i.data[ON_MSB:ON_LSB] : on_code_ff);
    assign nxt_per_code = timer_clear ? TIMER_RESET[PER_MSB:PER_LSB] :
                          (wr_timer ? frame_i.data[PER_MSB:PER_LSB] : per_code_ff);
    assign timer_load = wr_timer || timer_clear;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            on_code_ff <= TIMER_RESET[ON_MSB:ON_LSB];
            per_code_ff <= TIMER_RESET[PER_MSB:PER_LSB];
        end else begin
            on_code_ff <= nxt_on_code;
            per_code_ff <= nxt_per_code;
        end
    end

    // ----------------------------------------------------------------
    // Hardware control register
    // ----------------------------------------------------------------
    logic [7:0] hwctl_ff;
    logic [7:0] nxt_hwctl;
    logic [7:0] hw_wr_mask;
    logic [7:0] hw_written;
    logic [7:0] hw_soft_keep;
    logic [7:0] hw_soft_value;

    // Level-1 lock guards the rwl bits; level-0 lock is never self-locked.
    assign hw_wr_mask = lock1_ff ? (HWCTL_RD_MASK & ~HWCTL_LOCK1_MASK) : HWCTL_RD_MASK;
    assign hw_written = (hwctl_ff & ~hw_wr_mask) | (frame_i.data & hw_wr_mask);
    // Soft reset keeps what a set lock protects; with level-1 set that
    // equals the restart value, which leaves the bits as they are.
    assign hw_soft_keep = (lock1_ff ? HWCTL_LOCK1_MASK : 8'h00) |
                          (hwctl_ff[LOCK0_BIT] ? (8'h01 << LOCK0_BIT) : 8'h00);
    assign hw_soft_value = (hwctl_ff & hw_soft_keep) | (HWCTL_POR & ~hw_soft_keep);
    assign nxt_hwctl = soft_reset_i ? hw_soft_value :
                       (restart_i ? hwctl_ff :
                       (wr_hwctl ? hw_written : hwctl_ff));

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            hwctl_ff <= HWCTL_POR;
        end else begin
            hwctl_ff <= nxt_hwctl & HWCTL_RD_MASK;
        end
    end

    assign undervoltage_hysteresis_select_o = hwctl_ff[HYST_BIT];
    assign thermal_retry_delay_select_o = hwctl_ff[THERM_BIT];
    assign reset_delay_select_o = hwctl_ff[RSTDEL_BIT];
    assign level0_lock_o = hwctl_ff[LOCK0_BIT];
    // Software must drop the level-0 lock first; this permit enforces it.
    assign cp_pincfg_write_permit_o = !hwctl_ff[LOCK0_BIT];

    // ----------------------------------------------------------------
    // Thermal retry streak
    // ----------------------------------------------------------------
    logic streak_over;

    cth_event_streak #(
        .LIMIT(THERM_EVENT_LIMIT)
    ) u_streak (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .event_i(level2_thermal_shutdown_i),
        .clear_i(thermal_streak_clear_i),
        .exceeded_o(streak_over)
    );

    assign thermal_wait_extended_o = hwctl_ff[THERM_BIT] && streak_over;

    // ----------------------------------------------------------------
    // Cyclic timer and its two users
    // ----------------------------------------------------------------
    logic timer_out;
    logic period_start;

    cth_cycle_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .on_code_i(on_code_ff),
        .per_code_i(per_code_ff),
        .load_i(timer_load),
        .out_o(timer_out),
        .period_start_o(period_start)
    );

    // Wake and sense both tap the same timer and run side by side.
    logic wake_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= period_start && timer_wake_enable_i;
        end
    end

    assign high_side_output_o = timer_out;
    assign cyclic_sense_drive_o = timer_out && sense_mode;
    assign timer_wake_o = wake_ff;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic [7:0] timer_view;

    assign timer_view = {1'b0, on_code_ff, per_code_ff} & TIMER_RD_MASK;
    assign nxt_rd_data = (rd_addr_i == ADDR_TIMER) ? timer_view :
                         ((rd_addr_i == ADDR_HWCTL) ? (hwctl_ff & HWCTL_RD_MASK) : 8'h00);
    assign rd_data_o = rd_data_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end
endmodule : cth_ctrl_regs

// ### tb/cth_ctrl_regs_monitor.sv
// Port-level concurrent checks for the timer and lock register bank.
// Assumes the single system clock and its synchronous active-low reset.
`timescale 1ns/100ps
module cth_ctrl_regs_monitor (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic spi_chip_select_n_i,
    input wire logic [6:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic level1_lock_bit_i,
    input wire logic [2:0] pin_config_i,
    input wire logic timer_wake_enable_i,
    input wire logic high_side_output_o,
    input wire logic cyclic_sense_drive_o,
    input wire logic timer_wake_o,
    input wire logic undervoltage_hysteresis_select_o,
    input wire logic thermal_retry_delay_select_o,
    input wire logic thermal_wait_extended_o,
    input wire logic reset_delay_select_o,
    input wire logic level0_lock_o,
    input wire logic level1_lock_active_o,
    input wire logic cp_pincfg_write_permit_o
);
    import cth_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_permit_mirrors_lock: assert property ($past(resetn_i) |-> cp_pincfg_write_permit_o == !level0_lock_o)
        else $error("write permit does not mirror level-0 lock");
    a_sense_gated_pin: assert property ($past(resetn_i) |->
        cyclic_sense_drive_o == (high_side_output_o && pin_config_i == PINCFG_CYCLIC_SENSE))
        else $error("cyclic sense drive wrong for pin config");
    a_wake_needs_enable: assert property (timer_wake_o |-> timer_wake_enable_i || $past(timer_wake_enable_i))
        else $error("timer wake without enable");
    a_wake_single_cycle: assert property (timer_wake_o |=> !timer_wake_o)
        else $error("timer wake longer than one cycle");
    a_wake_at_period: assert property (timer_wake_o |-> high_side_output_o)
        else $error("timer wake not at period start");
    a_lock1_sticky: assert property (level1_lock_active_o |=> level1_lock_active_o)
        else $error("level-1 lock released");
    a_lock1_arms: assert property (spi_chip_select_n_i && !$past(spi_chip_select_n_i) && level1_lock_bit_i
        |=> level1_lock_active_o)
        else $error("level-1 lock not armed at chip select rise");
    a_lock1_holds: assert property ($past(level1_lock_active_o) |-> $stable({undervoltage_hysteresis_select_o,
        thermal_retry_delay_select_o, reset_delay_select_o}))
        else $error("locked bits changed");
    a_thermal_gated: assert property (thermal_wait_extended_o |-> thermal_retry_delay_select_o)
        else $error("extended wait without delay select");
    a_unmapped_zero: assert property ($past(rd_addr_i) != ADDR_TIMER && $past(rd_addr_i) != ADDR_HWCTL
        |-> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property ($past(rd_addr_i) == ADDR_HWCTL |-> (rd_data_o & ~HWCTL_RD_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    c_lock_armed: cover property ($rose(level1_lock_active_o));
    c_wake_pulse: cover property (timer_wake_o && cyclic_sense_drive_o);
    c_wait_extended: cover property ($rose(thermal_wait_extended_o));
endmodule : cth_ctrl_regs_monitor

bind cth_ctrl_regs cth_ctrl_regs_monitor u_monitor (.clk_sys_i, .resetn_i, .spi_chip_select_n_i, .rd_addr_i,
    .rd_data_o, .level1_lock_bit_i, .pin_config_i, .timer_wake_enable_i, .high_side_output_o, .cyclic_sense_drive_o,
    .timer_wake_o, .undervoltage_hysteresis_select_o, .thermal_retry_delay_select_o, .thermal_wait_extended_o,
    .reset_delay_select_o, .level0_lock_o, .level1_lock_active_o, .cp_pincfg_write_permit_o);

// ### tb/cth_spi_master_model.sv
// Microcontroller model that writes decoded SPI frames to the bank.
// Assumes the bank commits a frame at the first clock that sees chip select high.
`timescale 1ns/100ps
module cth_spi_master_model (
    input wire logic clk_sys_i,
    output logic spi_chip_select_n_o,
    output cth_pkg::cth_frame_t frame_o
);
    import cth_pkg::*;
    initial begin
        spi_chip_select_n_o = 1'b1;
        frame_o = '0;
    end
    // ----------------------------------------------------------------
    // Write frame
    // ----------------------------------------------------------------
    // The frame is inverted after the commit edge so a stale word never looks valid.
    task automatic write(input logic [6:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i);
        spi_chip_select_n_o <= 1'b0;
        frame_o <= '{wr: 1'b1, addr: addr, data: data};
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        spi_chip_select_n_o <= 1'b1;
        @(posedge clk_sys_i);
        frame_o <= ~frame_o;
        #1;
    endtask : write
endmodule : cth_spi_master_model

// ### tb/test_cth_ctrl_regs.sv
// Self-checking bench for the timer and lock register bank.
// Assumes a shortened prescaler of four cycles per 0.1 ms tick.
`timescale 1ns/100ps
module test_cth_ctrl_regs;
    import cth_pkg::*;
    localparam int TICK = 4;
    logic clk_sys_i, resetn, soft_rst, restart, hs_clr, therm_ev, therm_clr, lock1_bit, wake_en, cs_n;
    logic [2:0] pin_cfg;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic hs, sense, wake, hyst, therm_sel, therm_ext, rst_del, lock0, lock1_act, permit;
    cth_frame_t frame;
    int failures = 0;
    int compares = 0;
    int on_t[5] = '{1, 3, 10, 100, 200};
    int per_t[6] = '{100, 200, 500, 1000, 2000, 5000};
    cth_spi_master_model master (.clk_sys_i(clk_sys_i), .spi_chip_select_n_o(cs_n), .frame_o(frame));
    cth_ctrl_regs #(.TICK_CYC(TICK)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn), .spi_chip_select_n_i(cs_n),
        .frame_i(frame), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .soft_reset_i(soft_rst), .restart_i(restart),
        .restart_hs_cleared_i(hs_clr), .level1_lock_bit_i(lock1_bit), .pin_config_i(pin_cfg),
        .timer_wake_enable_i(wake_en), .level2_thermal_shutdown_i(therm_ev), .thermal_streak_clear_i(therm_clr),
        .high_side_output_o(hs), .cyclic_sense_drive_o(sense), .timer_wake_o(wake),
        .undervoltage_hysteresis_select_o(hyst), .thermal_retry_delay_select_o(therm_sel),
        .thermal_wait_extended_o(therm_ext), .reset_delay_select_o(rst_del), .level0_lock_o(lock0),
        .level1_lock_active_o(lock1_act), .cp_pincfg_write_permit_o(permit));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic end_of_test;
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step;
        @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) rd_addr <= a;
        repeat (2) @(posedge clk_sys_i);
        #1 check("rd_data", rd_data, e);
    endtask : chk_rd
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_sys_i) {soft_rst, restart, hs_clr, therm_ev, therm_clr} <= m;
        @(posedge clk_sys_i) {soft_rst, restart, hs_clr, therm_ev, therm_clr} <= 5'h00;
        #1;
    endtask : pulse
    task automatic run(input logic [7:0] v, output int hi, output int lo);
        int n;
        master.write(ADDR_TIMER, 8'h00);
        master.write(ADDR_TIMER, v);
        n = 0;
        hi = 0;
        lo = 0;
        while (hs !== 1'b1 && n < 30000) begin step(); n++; end
        while (hs === 1'b1 && hi < 30000) begin step(); hi++; end
        while (hs === 1'b0 && lo < 30000) begin step(); lo++; end
    endtask : run
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fields;
        chk_rd(ADDR_TIMER, 8'h00);
        chk_rd(ADDR_HWCTL, 8'h00);
        chk_rd(7'h05, 8'h00);
        master.write(ADDR_TIMER, 8'hff);
        chk_rd(ADDR_TIMER, 8'h7f);
        master.write(ADDR_HWCTL, 8'hff);
        chk_rd(ADDR_HWCTL, 8'hb8);
        check("selects", {hyst, therm_sel, rst_del, lock0, permit}, 5'h1e);
    endtask : t_fields
    task automatic t_timer;
        int hi, lo;
        for (int i = 0; i < 5; i++) begin
            run({1'b0, 3'(i + 1), 4'h2}, hi, lo);
            check("on_time", hi, on_t[i] * TICK);
            check("off_time", lo, (500 - on_t[i]) * TICK);
        end
        for (int p = 0; p < 6; p++) begin
            run({4'h1, 4'(p)}, hi, lo);
            check("period", hi + lo, per_t[p] * TICK);
        end
        master.write(ADDR_TIMER, 8'h60);
        repeat (20) step();
        check("hs_held_high", hs, 1'b1);
        master.write(ADDR_TIMER, 8'h70);
        repeat (20) step();
        check("hs_reserved_low", hs, 1'b0);
    endtask : t_timer
    task automatic t_wake(input logic en, input logic [2:0] cfg, input int exp_w, input int exp_s);
        int w, s;
        @(posedge clk_sys_i) {wake_en, pin_cfg} <= {en, cfg};
        master.write(ADDR_TIMER, 8'h10);
        w = 0;
        s = 0;
        repeat (600) begin
            step();
            w += (wake === 1'b1);
            s += (sense === 1'b1);
        end
        check("wake_pulses", w, exp_w);
        check("sense_cycles", s, exp_s);
    endtask : t_wake
    task automatic t_restart;
        master.write(ADDR_TIMER, 8'h13);
        pulse(5'h10);
        chk_rd(ADDR_TIMER, 8'h00);
        chk_rd(ADDR_HWCTL, 8'h08);
        master.write(ADDR_TIMER, 8'h13);
        pulse(5'h04);
        chk_rd(ADDR_TIMER, 8'h13);
        @(posedge clk_sys_i) pin_cfg <= PINCFG_CYCLIC_SENSE;
        pulse(5'h04);
        chk_rd(ADDR_TIMER, 8'h00);
        master.write(ADDR_TIMER, 8'h13);
        pulse(5'h08);
        chk_rd(ADDR_TIMER, 8'h00);
        chk_rd(ADDR_HWCTL, 8'h08);
        master.write(ADDR_TIMER, 8'h13);
        pulse(5'h02);
        chk_rd(ADDR_TIMER, 8'h13);
    endtask : t_restart
    task automatic t_locks;
        pulse(5'h10);
        chk_rd(ADDR_TIMER, 8'h00);
        chk_rd(ADDR_HWCTL, 8'h08);
        @(posedge clk_sys_i) lock1_bit <= 1'b1;
        master.write(ADDR_HWCTL, 8'hb8);
        check("lock1_active", lock1_act, 1'b1);
        master.write(ADDR_HWCTL, 8'h08);
        chk_rd(ADDR_HWCTL, 8'hb8);
        pulse(5'h10);
        chk_rd(ADDR_HWCTL, 8'hb8);
        master.write(ADDR_HWCTL, 8'h00);
        chk_rd(ADDR_HWCTL, 8'hb0);
        check("permit", permit, 1'b1);
        @(posedge clk_sys_i) lock1_bit <= 1'b0;
        repeat (3) step();
        check("lock1_kept", lock1_act, 1'b1);
    endtask : t_locks
    task automatic t_thermal;
        pulse(5'h01);
        repeat (16) pulse(5'h02);
        check("wait_16", therm_ext, 1'b0);
        pulse(5'h02);
        check("wait_17", therm_ext, 1'b1);
        pulse(5'h01);
        check("wait_cleared", therm_ext, 1'b0);
        @(posedge clk_sys_i) resetn <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        resetn <= 1'b1;
        step();
        check("lock1_powerup", lock1_act, 1'b0);
        chk_rd(ADDR_HWCTL, 8'h00);
    endtask : t_thermal
    initial begin
        #1_000_000;
        failures++;
        end_of_test();
    end
    initial begin
        {resetn, soft_rst, restart, hs_clr, therm_ev, therm_clr, lock1_bit, wake_en} = 8'h00;
        pin_cfg = 3'h0;
        rd_addr = 7'h00;
        repeat (3) @(posedge clk_sys_i);
        resetn <= 1'b1;
        step();
        t_fields();
        t_timer();
        t_wake(1'b1, PINCFG_CYCLIC_SENSE, 2, 2 * TICK);
        t_wake(1'b0, 3'h4, 0, 0);
        t_restart();
        t_locks();
        t_thermal();
        end_of_test();
    end
endmodule : test_cth_ctrl_regs
